// File: hdl/mpc_pkg.sv
// Package for the monitor pin control block: pulse timing, pin indices,
// reset values and the control and status carriers.
// Assumes a single 100 MHz system clock.
package mpc_pkg;

   localparam int CLK_FREQ_KHZ = 100_000;
   // Least low time of the intrusion-clear and master-reset pulses
   localparam int PULSE_MIN_MS = 10;
   localparam int PULSE_CYCLES = PULSE_MIN_MS * CLK_FREQ_KHZ;

   // Synchronised pin vector layout
   localparam int PIN_INT_N  = 0;
   localparam int PIN_SCL    = 1;
   localparam int PIN_BTI_N  = 2;
   localparam int PIN_CI     = 3;
   localparam int PIN_TTR_N  = 4;
   localparam int PIN_A0     = 5;
   localparam int PIN_A1     = 6;
   localparam int PIN_COUNT  = 8;
   // Idle levels: active-low pins high, intrusion low
   localparam logic [PIN_COUNT-1:0] PIN_RST = 8'h17;

   // Straps are captured this many cycles plus one after reset or test mode ends
   localparam logic [1:0] STRAP_SETTLE = 2'h3;

   // Voltage coding: 8-bit code, 10 mV per step, 2.56 V full scale
   localparam int VOLT_BITS    = 8;
   localparam int VOLT_LSB_MV  = 10;
   localparam int VOLT_FULL_MV = 2560;
   localparam logic [11:0] VOLT_SAT_MV = 12'(VOLT_FULL_MV - VOLT_LSB_MV);

   typedef struct packed {
      logic int_enable;        // Interrupt output enable
      logic int_mode_nmi;      // 1: open-source NMI, 0: open-drain IRQ
      logic intrusion_clear;   // Rising edge starts intrusion line clear
      logic reset_out_enable;  // Master reset enable, configuration side
      logic reset_func_enable; // Master reset enable, divisor side
      logic overtemp_mode;     // Shared output acts as overtemp shutdown
      logic ext_int_mask;      // 1 masks the external interrupt input
      logic bti_int_mask;      // 1 masks the board temperature interrupt
      logic power_switch_on;   // Pull the power switch output low
      logic reset_pulse_req;   // One-cycle request for a master reset
      logic overtemp_event;    // Overtemperature condition from monitor
      logic intrusion_ack;     // Clears the latched intrusion event
      logic temp_status_ack;   // Clears the board temperature status
      logic sda_pull_low;      // Serial engine wants data line low
   } mpc_ctrl_t;

   typedef struct packed {
      logic intrusion;
      logic board_temp;
      logic ext_int;
      logic reset_busy;
   } mpc_status_t;

   localparam mpc_status_t STATUS_RST = '0;

endpackage

// File: hdl/mpc_pulse_timer.sv
// Fixed-length pulse generator: busy for exactly CYCLES clocks after start.
// Assumes start and clear come from logic on the same clock.
`timescale 1ns/1ps
module mpc_pulse_timer #(
   parameter int CYCLES = 10
) (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic clear_i,
   input  wire logic start_i,
   output logic      busy_o
);
   localparam int W = $clog2(CYCLES + 1);

   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic         busy_r;
   logic         busy_nxt;

   always_comb begin
      cnt_nxt  = cnt_r;
      busy_nxt = busy_r;
      if (clear_i) begin
         cnt_nxt  = '0;
         busy_nxt = 1'b0;
      end else if (busy_r) begin
         if (cnt_r == W'(CYCLES - 1)) begin
            cnt_nxt  = '0;
            busy_nxt = 1'b0;
         end else begin
            cnt_nxt = cnt_r + W'(1);
         end
      end else if (start_i) begin
         cnt_nxt  = '0;
         busy_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         busy_r <= busy_nxt;
      end
   end

   assign busy_o = busy_r;

endmodule

// File: hdl/mpc_pin_ctrl.sv
// Pin-level control of a serial-bus hardware monitor: interrupt routing,
// intrusion latch and clear, power switch, reset/overtemp output, straps.
// Assumes ctrl_i and volt_mv_i come from logic on clk_i; pins are async.
// Functional notes
// - External interrupt reaches the output only if unmasked and enabled.
// - Serial data is only pulled low or released; serial clock is input.
// - High intrusion input latches an event that stays until cleared.
// - Clear request pulls intrusion line low for at least 10 ms.
// - Mode bit picks open-source NMI or open-drain IRQ output.
// - Interrupt output is off after reset until enable is set.
// - Active-low open-drain power switch output under software control.
// - Test input low enters tree test and returns state to power-on.
// - Master reset drives shared output low at least 10 ms.
// - Master reset works only when both enable bits are set.
// - Overtemp mode makes shared output an active-low shutdown flag.
// - Strap zero gives address bit zero, becomes tree result in test.
// - Two upper straps give the upper strap bits of the address.
// - Board temperature input shows as a status bit.
// - Voltages coded in 8 bits, 10 mV per step, 2.56 V full scale.
`timescale 1ns/1ps
module mpc_pin_ctrl #(
   parameter int         CI_CLR_CYCLES  = mpc_pkg::PULSE_CYCLES,
   parameter int         RST_OUT_CYCLES = mpc_pkg::PULSE_CYCLES,
   parameter logic [3:0] ADDR_BASE      = 4'h4  // Arbitrary fixed upper bits
) (
   input  wire logic                 clk_i,
   input  wire logic                 rstn_i,
   input  wire mpc_pkg::mpc_ctrl_t   ctrl_i,
   input  wire logic [11:0]          volt_mv_i,
   input  wire logic                 int_in_n_i,
   input  wire logic                 scl_i,
   input  wire logic                 board_temp_alert_input_n_i,
   input  wire logic                 chassis_intrusion_line_i,
   input  wire logic                 tree_test_reset_input_n_i,
   input  wire logic                 address_bit0_tree_result_i,
   input  wire logic [1:0]           upper_address_straps_i,
   output logic                      int_o,
   output logic                      int_oe_o,
   output logic                      sda_o,
   output logic                      sda_oe_o,
   output logic                      scl_level_o,
   output logic                      scl_rise_o,
   output logic                      scl_fall_o,
   output logic                      chassis_intrusion_line_o,
   output logic                      chassis_intrusion_line_oe_o,
   output logic                      power_switch_output_n_o,
   output logic                      power_switch_output_oe_o,
   output logic                      reset_or_overtemp_output_n_o,
   output logic                      reset_or_overtemp_output_oe_o,
   output logic                      address_bit0_tree_result_o,
   output logic                      address_bit0_tree_result_oe_o,
   output logic [6:0]                bus_address_o,
   output mpc_pkg::mpc_status_t      status_o,
   output logic [7:0]                volt_code_o,
   output logic                      test_mode_o
);
   localparam int PC = mpc_pkg::PIN_COUNT;

   logic [PC-1:0]        sync1_r;
   logic [PC-1:0]        sync2_r;
   logic [PC-1:0]        pins;
   logic                 test_now;
   logic                 ci_busy;
   logic                 rst_busy;
   logic                 ci_start;
   logic                 rst_start;
   logic                 rst_allowed;
   logic                 pending;
   logic [11:0]          volt_q;

   mpc_pkg::mpc_status_t st_r,      st_nxt;
   logic                 scl_r,     scl_nxt;
   logic                 scl_rise_r, scl_rise_nxt;
   logic                 scl_fall_r, scl_fall_nxt;
   logic                 clr_prev_r, clr_prev_nxt;
   logic                 int_r,     int_nxt;
   logic                 int_oe_r,  int_oe_nxt;
   logic                 sda_oe_r,  sda_oe_nxt;
   logic                 ci_oe_r,   ci_oe_nxt;
   logic                 psw_oe_r,  psw_oe_nxt;
   logic                 ro_oe_r,   ro_oe_nxt;
   logic                 tree_r,    tree_nxt;
   logic                 tree_oe_r, tree_oe_nxt;
   logic [1:0]           strap_cnt_r, strap_cnt_nxt;
   logic                 strap_done_r, strap_done_nxt;
   logic [6:0]           addr_r,    addr_nxt;
   logic [7:0]           volt_r,    volt_nxt;
   logic                 test_r,    test_nxt;

   assign pins = {upper_address_straps_i, address_bit0_tree_result_i,
                  tree_test_reset_input_n_i, chassis_intrusion_line_i,
                  board_temp_alert_input_n_i, scl_i, int_in_n_i};

   // Two-stage synchroniser for every pin
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_r <= mpc_pkg::PIN_RST;
         sync2_r <= mpc_pkg::PIN_RST;
      end else begin
         sync1_r <= pins;
         sync2_r <= sync1_r;
      end
   end

   assign test_now    = !sync2_r[mpc_pkg::PIN_TTR_N];
   assign rst_allowed = ctrl_i.reset_out_enable && ctrl_i.reset_func_enable;
   assign ci_start    = ctrl_i.intrusion_clear && !clr_prev_r && !test_now;
   assign rst_start   = rst_allowed && ctrl_i.reset_pulse_req && !test_now;
   assign volt_q      = volt_mv_i / 12'(mpc_pkg::VOLT_LSB_MV);

   mpc_pulse_timer #(.CYCLES(CI_CLR_CYCLES)) u_ci_timer (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .clear_i (test_now),
      .start_i (ci_start),
      .busy_o  (ci_busy)
   );

   mpc_pulse_timer #(.CYCLES(RST_OUT_CYCLES)) u_rst_timer (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .clear_i (test_now),
      .start_i (rst_start),
      .busy_o  (rst_busy)
   );

   always_comb begin
      pending = (!sync2_r[mpc_pkg::PIN_INT_N] && !ctrl_i.ext_int_mask)
              || (st_r.board_temp && !ctrl_i.bti_int_mask);
      st_nxt.intrusion  = sync2_r[mpc_pkg::PIN_CI]
                        || (st_r.intrusion && !ctrl_i.intrusion_ack);
      st_nxt.board_temp = !sync2_r[mpc_pkg::PIN_BTI_N]
                        || (st_r.board_temp && !ctrl_i.temp_status_ack);
      st_nxt.ext_int    = !sync2_r[mpc_pkg::PIN_INT_N];
      st_nxt.reset_busy = rst_busy;
      scl_nxt       = sync2_r[mpc_pkg::PIN_SCL];
      scl_rise_nxt  = sync2_r[mpc_pkg::PIN_SCL] && !scl_r;
      scl_fall_nxt  = !sync2_r[mpc_pkg::PIN_SCL] && scl_r;
      clr_prev_nxt  = ctrl_i.intrusion_clear;
      int_oe_nxt    = ctrl_i.int_enable && pending;
      int_nxt       = ctrl_i.int_mode_nmi;
      sda_oe_nxt    = ctrl_i.sda_pull_low;
      ci_oe_nxt     = ci_busy;
      psw_oe_nxt    = ctrl_i.power_switch_on;
      ro_oe_nxt     = rst_busy
                    || (ctrl_i.overtemp_mode && ctrl_i.overtemp_event);
      tree_nxt      = ~&{sync2_r[PC-1:mpc_pkg::PIN_A1], sync2_r[mpc_pkg::PIN_CI:0]};
      tree_oe_nxt   = 1'b0;
      strap_cnt_nxt = strap_cnt_r;
      strap_done_nxt = strap_done_r;
      addr_nxt      = addr_r;
      if (!strap_done_r) begin
         if (strap_cnt_r == mpc_pkg::STRAP_SETTLE) begin
            strap_done_nxt = 1'b1;
            addr_nxt = {ADDR_BASE, sync2_r[PC-1:mpc_pkg::PIN_A1],
                        sync2_r[mpc_pkg::PIN_A0]};
         end else begin
            strap_cnt_nxt = strap_cnt_r + 2'h1;
         end
      end
      if (volt_q > 12'(2 ** mpc_pkg::VOLT_BITS - 1)) begin
         volt_nxt = 8'hff;
      end else begin
         volt_nxt = volt_q[7:0];
      end
      test_nxt = test_now;
      // Test mode returns the state to power-on, with the tree result output enabled
      if (test_now) begin
         st_nxt         = mpc_pkg::STATUS_RST;
         clr_prev_nxt   = 1'b0;
         int_oe_nxt     = 1'b0;
         int_nxt        = 1'b0;
         sda_oe_nxt     = 1'b0;
         ci_oe_nxt      = 1'b0;
         psw_oe_nxt     = 1'b0;
         ro_oe_nxt      = 1'b0;
         volt_nxt       = 8'h00;
         strap_cnt_nxt  = 2'h0;
         strap_done_nxt = 1'b0;
         addr_nxt       = 7'h00;
         tree_oe_nxt    = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r         <= mpc_pkg::STATUS_RST;
         scl_r        <= 1'b1;
         scl_rise_r   <= 1'b0;
         scl_fall_r   <= 1'b0;
         clr_prev_r   <= 1'b0;
         int_r        <= 1'b0;
         int_oe_r     <= 1'b0;
         sda_oe_r     <= 1'b0;
         ci_oe_r      <= 1'b0;
         psw_oe_r     <= 1'b0;
         ro_oe_r      <= 1'b0;
         tree_r       <= 1'b0;
         tree_oe_r    <= 1'b0;
         strap_cnt_r  <= 2'h0;
         strap_done_r <= 1'b0;
         addr_r       <= 7'h00;
         volt_r       <= 8'h00;
         test_r       <= 1'b0;
      end else begin
         st_r         <= st_nxt;
         scl_r        <= scl_nxt;
         scl_rise_r   <= scl_rise_nxt;
         scl_fall_r   <= scl_fall_nxt;
         clr_prev_r   <= clr_prev_nxt;
         int_r        <= int_nxt;
         int_oe_r     <= int_oe_nxt;
         sda_oe_r     <= sda_oe_nxt;
         ci_oe_r      <= ci_oe_nxt;
         psw_oe_r     <= psw_oe_nxt;
         ro_oe_r      <= ro_oe_nxt;
         tree_r       <= tree_nxt;
         tree_oe_r    <= tree_oe_nxt;
         strap_cnt_r  <= strap_cnt_nxt;
         strap_done_r <= strap_done_nxt;
         addr_r       <= addr_nxt;
         volt_r       <= volt_nxt;
         test_r       <= test_nxt;
      end
   end

   // Open-drain pins drive a constant low; only the enables move
   assign int_o                         = int_r;
   assign int_oe_o                      = int_oe_r;
   assign sda_o                         = 1'b0;
   assign sda_oe_o                      = sda_oe_r;
   assign scl_level_o                   = scl_r;
   assign scl_rise_o                    = scl_rise_r;
   assign scl_fall_o                    = scl_fall_r;
   assign chassis_intrusion_line_o      = 1'b0;
   assign chassis_intrusion_line_oe_o   = ci_oe_r;
   assign power_switch_output_n_o       = 1'b0;
   assign power_switch_output_oe_o      = psw_oe_r;
   assign reset_or_overtemp_output_n_o  = 1'b0;
   assign reset_or_overtemp_output_oe_o = ro_oe_r;
   assign address_bit0_tree_result_o    = tree_r;
   assign address_bit0_tree_result_oe_o = tree_oe_r;
   assign bus_address_o                 = addr_r;
   assign status_o                      = st_r;
   assign volt_code_o                   = volt_r;
   assign test_mode_o                   = test_r;

   // Helper counters of low-pulse length
   int ci_len_r;
   int ro_len_r;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ci_len_r <= 0;
         ro_len_r <= 0;
      end else begin
         ci_len_r <= ci_oe_r ? ci_len_r + 1 : 0;
         ro_len_r <= (ro_oe_r && st_r.reset_busy) ? ro_len_r + 1 : 0;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   a_int_ext_gate: assert property (int_oe_o && !$past(st_r.board_temp) |->
      !$past(sync2_r[0]) && !$past(ctrl_i.ext_int_mask)) else $error("int without source");
   a_int_enable: assert property (int_oe_o |-> $past(ctrl_i.int_enable))
      else $error("int asserted while disabled");
   a_int_mode: assert property (int_oe_o |-> int_o == $past(ctrl_i.int_mode_nmi))
      else $error("int drive mode wrong");
   a_int_pending: assert property (ctrl_i.int_enable && pending && !test_now |=> int_oe_o)
      else $error("pending interrupt not driven");
   a_sda_low_only: assert property ($rose(ctrl_i.sda_pull_low) && !test_now
      |=> sda_oe_o && !sda_o) else $error("data line not pulled low");
   a_intrusion_sticky: assert property (status_o.intrusion && !ctrl_i.intrusion_ack
      && !test_now |=> status_o.intrusion) else $error("intrusion lost");
   a_ci_pulse_len: assert property ($fell(chassis_intrusion_line_oe_o) && !test_r
      |-> ci_len_r >= CI_CLR_CYCLES) else $error("intrusion clear too short");
   a_psw_follow: assert property (!test_now |=>
      power_switch_output_oe_o == $past(ctrl_i.power_switch_on)) else $error("power switch wrong");
   a_test_clears: assert property (test_now |=> !status_o.intrusion && !int_oe_o
      && !chassis_intrusion_line_oe_o && address_bit0_tree_result_oe_o) else $error("test no reset");
   a_rst_pulse_len: assert property ($fell(status_o.reset_busy) && !test_r
      |-> ro_len_r >= RST_OUT_CYCLES) else $error("master reset too short");
   a_rst_enable: assert property ($rose(rst_busy) |-> $past(rst_allowed))
      else $error("master reset while disabled");
   a_os_follow: assert property (ctrl_i.overtemp_mode && ctrl_i.overtemp_event
      && !test_now |=> reset_or_overtemp_output_oe_o) else $error("overtemp not shown");
   a_addr_capture: assert property ($rose(strap_done_r) |-> bus_address_o[2:0]
      == $past(sync2_r[7:5])) else $error("strap address wrong");
   a_addr_upper: assert property (strap_done_r |-> bus_address_o[6:3] == ADDR_BASE)
      else $error("fixed address bits wrong");
   a_bti_status: assert property (!sync2_r[2] && !test_now |=> status_o.board_temp)
      else $error("board temp status missed");
   a_volt_code: assert property (!test_now && volt_mv_i <= mpc_pkg::VOLT_SAT_MV |=>
      int'(volt_code_o) == int'($past(volt_mv_i)) / mpc_pkg::VOLT_LSB_MV)
      else $error("voltage code wrong");

   c_int_nmi: cover property (int_oe_o && int_o);
   c_ci_clear: cover property ($fell(chassis_intrusion_line_oe_o));
   c_rst_pulse: cover property ($rose(status_o.reset_busy));
   c_test_mode: cover property ($rose(test_mode_o));

endmodule

// File: test/mpc_host_model.sv
// Behavioural two-wire bus host: one eight-bit frame for each rise of start_i.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
module mpc_host_model (
   input  wire logic       start_i,
   input  wire logic       sda_i,
   output logic            scl_o,
   output logic            sda_low_o,
   output logic [7:0]      sampled_o
);
   initial begin
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
      sampled_o = 8'h00;
   end
   // Clock stands high outside frames; data released while device answers
   always @(posedge start_i) begin
      sda_low_o = 1'b1;
      repeat (8) begin
         #62.5 scl_o = 1'b0;
         sda_low_o = 1'b0;
         #62.5 scl_o = 1'b1;
         sampled_o = {sampled_o[6:0], sda_i};
      end
      #62.5 sda_low_o = 1'b1;
      #62.5 sda_low_o = 1'b0;
   end
endmodule

// File: test/test_mpc_pin_ctrl.sv
// Self-checking bench for the monitor pin control block.
// Assumes shortened pulse counts and a host model on the serial pins.
`timescale 1ns/1ps
module test_mpc_pin_ctrl;
   localparam int PULSE = 20;
   logic               clk_i   = 1'b0;
   logic               rstn_i  = 1'b0;
   mpc_pkg::mpc_ctrl_t ctrl    = '0;
   logic [11:0]        volt_mv = 12'h000;
   logic               int_n   = 1'b1;
   logic               bti_n   = 1'b1;
   logic               ci_ext  = 1'b0;
   logic               ttr_n   = 1'b1;
   logic               a0      = 1'b1;
   logic [1:0]         a12     = 2'h2;
   logic               host_go = 1'b0;
   logic               scl, host_low, sda, sda_o, sda_oe, rise, ci_o, ci_oe, ps_n, ps_oe;
   logic               int_v, int_oe, rs_n, rs_oe, a0_o, a0_oe, tmode;
   logic               scl_lv, fall;
   logic [7:0]         sampled, vcode;
   logic [6:0]         baddr;
   mpc_pkg::mpc_status_t st;
   int                 num_errors = 0;
   int                 n_compared = 0;
   int                 cyc = 0;
   int                 rises = 0;
   int                 ci_len = 0;
   int                 rs_len = 0;
   int                 falls = 0;
   int                 ci0 = 0;
   int                 rs0 = 0;
   logic [11:0]        mv_tab [5] = '{12'h000, 12'h4d2, 12'h9f5, 12'ha00, 12'hfff};
   logic [7:0]         cd_tab [5] = '{8'h00, 8'h7b, 8'hfe, 8'hff, 8'hff};

   assign sda = !(host_low || (sda_oe && !sda_o));
   always #5 clk_i = ~clk_i;

   mpc_host_model host (.start_i(host_go), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low),
                        .sampled_o(sampled));

   mpc_pin_ctrl #(.CI_CLR_CYCLES(PULSE), .RST_OUT_CYCLES(PULSE)) dut (
      .clk_i(clk_i), .rstn_i(rstn_i), .ctrl_i(ctrl), .volt_mv_i(volt_mv),
      .int_in_n_i(int_n), .scl_i(scl), .board_temp_alert_input_n_i(bti_n),
      .chassis_intrusion_line_i(ci_ext && !ci_oe), .tree_test_reset_input_n_i(ttr_n),
      .address_bit0_tree_result_i(a0_oe ? a0_o : a0), .upper_address_straps_i(a12),
      .int_o(int_v), .int_oe_o(int_oe), .sda_o(sda_o), .sda_oe_o(sda_oe),
      .scl_level_o(scl_lv), .scl_rise_o(rise), .scl_fall_o(fall),
      .chassis_intrusion_line_o(ci_o), .chassis_intrusion_line_oe_o(ci_oe),
      .power_switch_output_n_o(ps_n), .power_switch_output_oe_o(ps_oe),
      .reset_or_overtemp_output_n_o(rs_n), .reset_or_overtemp_output_oe_o(rs_oe),
      .address_bit0_tree_result_o(a0_o), .address_bit0_tree_result_oe_o(a0_oe),
      .bus_address_o(baddr), .status_o(st), .volt_code_o(vcode), .test_mode_o(tmode));

   // Cycle counter cuts a hang short; pulse widths counted in clock cycles
   always @(posedge clk_i) begin
      cyc++;
      if (rise === 1'b1) rises++;
      if (fall === 1'b1) falls++;
      if (ci_oe === 1'b1) ci_len++;
      if (rs_oe === 1'b1) rs_len++;
      if (cyc == 20000) begin
         num_errors++;
         stop_test();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic stop_test();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clk_i);
      rstn_i <= 1'b1;
      tick(1);
      chk("idle enables", 12'h000, {8'h00, int_oe, ci_oe, rs_oe, ps_oe});
      chk("idle status", 12'h000, {8'h00, st});
      tick(6);
      chk("bus address", 12'h025, {5'h00, baddr});
      // Serial wire: pulled low, then released to the pull-up
      ctrl.sda_pull_low <= 1'b1;
      tick(2);
      chk("sda drive", 12'h002, {10'h000, sda_oe, sda_o});
      host_go <= 1'b1;
      tick(150);
      chk("host sampled low", 12'h000, {4'h0, sampled});
      ctrl.sda_pull_low <= 1'b0;
      host_go <= 1'b0;
      tick(2);
      host_go <= 1'b1;
      tick(150);
      chk("host sampled released", 12'h0ff, {4'h0, sampled});
      chk("scl rises", 12'h010, 12'(rises));
      chk("scl falls", 12'h010, 12'(falls));
      chk("scl idle level", 12'h001, {11'h000, scl_lv});
      for (int i = 0; i < 5; i++) begin
         volt_mv <= mv_tab[i];
         tick(2);
         chk("volt code", {4'h0, cd_tab[i]}, {4'h0, vcode});
      end
      // External interrupt through enable, mask and both modes
      int_n <= 1'b0;
      tick(6);
      chk("int disabled", 12'h000, {11'h000, int_oe});
      ctrl.int_enable <= 1'b1;
      ctrl.ext_int_mask <= 1'b1;
      tick(3);
      chk("int masked", 12'h000, {11'h000, int_oe});
      for (int m = 0; m < 2; m++) begin
         ctrl.ext_int_mask <= 1'b0;
         ctrl.int_mode_nmi <= m[0];
         tick(3);
         chk("int mode", {10'h000, 1'b1, m[0]}, {10'h000, int_oe, int_v});
      end
      int_n <= 1'b1;
      tick(6);
      chk("int released", 12'h000, {11'h000, int_oe});
      bti_n <= 1'b0;
      tick(6);
      bti_n <= 1'b1;
      tick(6);
      chk("board temp held", 12'h003, {10'h000, st.board_temp, int_oe});
      ctrl.bti_int_mask <= 1'b1;
      tick(3);
      chk("board temp masked", 12'h002, {10'h000, st.board_temp, int_oe});
      ctrl.bti_int_mask <= 1'b0;
      ctrl.temp_status_ack <= 1'b1;
      tick(3);
      chk("board temp acked", 12'h000, {10'h000, st.board_temp, int_oe});
      ctrl.temp_status_ack <= 1'b0;
      // Intrusion latch, acknowledge, and line clear pulse
      ci_ext <= 1'b1;
      tick(6);
      ci_ext <= 1'b0;
      tick(6);
      chk("intrusion latched", 12'h001, {11'h000, st.intrusion});
      ctrl.intrusion_ack <= 1'b1;
      tick(3);
      chk("intrusion acked", 12'h000, {11'h000, st.intrusion});
      ctrl.intrusion_ack <= 1'b0;
      ci0 = ci_len;
      ctrl.intrusion_clear <= 1'b1;
      tick(PULSE + 10);
      chk("clear pulse", 12'(PULSE), 12'(ci_len - ci0));
      chk("clear level", 12'h000, {11'h000, ci_o});
      ctrl.intrusion_clear <= 1'b0;
      ctrl.power_switch_on <= 1'b1;
      tick(2);
      chk("power switch", 12'h002, {10'h000, ps_oe, ps_n});
      // Master reset needs the divisor-side enable as well as the configuration one
      for (int e = 0; e < 2; e++) begin
         rs0 = rs_len;
         ctrl.reset_out_enable <= 1'b1;
         ctrl.reset_func_enable <= e[0];
         ctrl.reset_pulse_req <= 1'b1;
         tick(1);
         ctrl.reset_pulse_req <= 1'b0;
         tick(PULSE + 10);
         chk("reset pulse", e ? 12'(PULSE) : 12'h000, 12'(rs_len - rs0));
         chk("reset level", 12'h000, {11'h000, rs_n});
      end
      ctrl.overtemp_mode <= 1'b1;
      ctrl.overtemp_event <= 1'b1;
      tick(3);
      chk("overtemp on", 12'h001, {11'h000, rs_oe});
      ctrl.overtemp_event <= 1'b0;
      tick(3);
      chk("overtemp off", 12'h000, {11'h000, rs_oe});
      // Tree test returns state to power-on and turns strap zero around
      ci_ext <= 1'b1;
      tick(6);
      ci_ext <= 1'b0;
      ttr_n <= 1'b0;
      tick(6);
      chk("test state", 12'h00c, {8'h00, tmode, a0_oe, ps_oe, st.intrusion});
      chk("tree result", 12'h001, {11'h000, a0_o});
      ttr_n <= 1'b1;
      tick(10);
      chk("test exit", 12'h025, {4'h0, tmode, baddr});
      stop_test();
   end
endmodule
